/* File: src/sabc_dev.sv */
// Converter end: control logic, approximation sequencer, output drivers.
module sabc_dev (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Bus pins.
   sabc_if.dev bus,
   // Format strap and analog comparator result.
   input wire logic i_word_format_select,
   input wire logic i_cmp_high,
   // Status toward the user side.
   output logic o_short_cycle_done,
   output logic o_full_cycle_done,
   output logic [11:0] o_result
);
   typedef enum logic [1:0] {SABC_IDLE, SABC_CONV} sabc_state_e;
   sabc_state_e state;
   logic [sabc_pkg::STEP_W-1:0] step_cnt;
   logic [3:0] bit_cnt;
   logic [3:0] bit_goal;
   logic [11:0] trial;
   logic fmt;
   logic [11:0] next_out;
   logic [11:0] next_oe_n;

   // Strap caught once after reset; later changes are not logic input.
   logic fmt_taken;
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         fmt_taken <= 1'b0;
         fmt <= 1'b0;
      end else if (!fmt_taken) begin
         fmt_taken <= 1'b1;
         fmt <= i_word_format_select;
      end
   end

   // Chip access decode.
   wire access = bus.chip_en && !bus.sel_n;
   wire start_req = access && !bus.read_convert;
   wire read_req = access && bus.read_convert;
   wire idle = (state == SABC_IDLE);
   wire step_end = (step_cnt == sabc_pkg::STEP_LAST);
   wire [3:0] bit_idx = 4'(11 - bit_cnt);
   wire last_bit = step_end && (bit_cnt + 4'h1 == bit_goal);

   // Approximation sequencer; one bit resolved per step.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= SABC_IDLE;
         step_cnt <= '0;
         bit_cnt <= 4'h0;
         bit_goal <= sabc_pkg::BITS_FULL;
         trial <= 12'h000;
         o_result <= 12'h000;
         bus.conv_busy <= 1'b0;
         o_short_cycle_done <= 1'b1;
         o_full_cycle_done <= 1'b1;
      end else begin
         case (state)
            SABC_IDLE: begin
               if (start_req) begin
                  state <= SABC_CONV;
                  bit_goal <= bus.byte_length_select ? sabc_pkg::BITS_SHORT
                     : sabc_pkg::BITS_FULL;
                  step_cnt <= '0;
                  bit_cnt <= 4'h0;
                  trial <= 12'h000;
                  bus.conv_busy <= 1'b1;
                  o_short_cycle_done <= 1'b0;
                  o_full_cycle_done <= 1'b0;
               end
            end
            SABC_CONV: begin
               step_cnt <= step_end ? '0 : step_cnt + 1'b1;
               if (step_end) begin
                  trial[bit_idx] <= i_cmp_high;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt + 4'h1 == sabc_pkg::BITS_SHORT)
                     o_short_cycle_done <= 1'b1;
               end
               if (last_bit) begin
                  state <= SABC_IDLE;
                  bus.conv_busy <= 1'b0;
                  o_full_cycle_done <= 1'b1;
                  // Held until the next conversion ends.
                  o_result <= {trial[11:1], 1'b0} |
                     (12'h001 << bit_idx) & {12{i_cmp_high}};
               end
            end
            default: state <= SABC_IDLE;
         endcase
      end
   end

   // Output selection; drivers stay off while converting.
   always_comb begin
      next_out = 12'h000;
      next_oe_n = 12'hFFF;
      if (read_req && idle) begin
         if (fmt) begin
            next_out = o_result;
            next_oe_n = 12'h000;
         end else if (!bus.byte_length_select) begin
            next_out = {4'h0, o_result[11:4]};
            next_oe_n = 12'hF00;
         end else begin
            next_out = {4'h0, o_result[3:0], sabc_pkg::ZERO_NIB};
            next_oe_n = 12'hF00;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         bus.data_out <= 12'h000;
         bus.data_oe_n <= 12'hFFF;
      end else begin
         bus.data_out <= next_out;
         bus.data_oe_n <= next_oe_n;
      end
   end
endmodule

/* File: src/sabc_pkg.sv */
// What this block does
// - Enable and select active: read or convert
// - Length select low starts full cycle
// - Length select high starts 8-bit cycle
// - Byte read: MSB byte or LSB nibble
// - Format strap is static, never toggled
// - Word format reads all twelve bits
// - LSB byte: nibble high, zeros low
// - Busy rises at start, falls at end
// - Done flags drop, rise at 8/12 bits
// - Starts during conversion are ignored
// - Data drivers off throughout conversion
// - Host sets convert level before enabling
// - Host may finish start with either
// - Host settles length select before read
package sabc_pkg;
   // Converter clock rate and documented conversion times.
   localparam int CLK_MHZ = 25;
   localparam int CONV8_US = 10;
   localparam int CONV12_US = 15;
   // One bit decision per step; step length derived from the 12-bit conversion time.
   localparam int STEP_CYC = (CONV12_US * CLK_MHZ) / 12;
   localparam int STEP_W = 10;
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
   // Host settle time for the length select ahead of chip enable.
   localparam int SETTLE_NS = 150;
   localparam int CLK_NS = 40;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   // Result width and bit counts of the two cycle lengths.
   localparam int RES_W = 12;
   localparam logic [3:0] BITS_SHORT = 4'h8;
   localparam logic [3:0] BITS_FULL = 4'hC;
   localparam logic [3:0] ZERO_NIB = 4'h0;
   // Host operation codes.
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_CONV = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
endpackage

/* File: src/sabc_if.sv */
// Pins between the converter control and the bus host.
interface sabc_if;
   logic chip_en;
   logic sel_n;
   logic read_convert;
   logic byte_length_select;
   logic conv_busy;
   logic [11:0] data_out;
   logic [11:0] data_oe_n;

   modport dev (
      input chip_en, sel_n, read_convert, byte_length_select,
      output conv_busy, data_out, data_oe_n
   );
   modport host (
      output chip_en, sel_n, read_convert, byte_length_select,
      input conv_busy, data_out, data_oe_n
   );
endinterface

/* File: src/sabc_host.sv */
// Host end: turns one-cycle user commands into bus pin sequences.
module sabc_host (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Bus pins.
   sabc_if.host bus,
   // User commands.
   input wire logic [1:0] i_op,
   input wire logic i_len,
   // User answers.
   output logic o_busy,
   output logic o_rd_valid,
   output logic [11:0] o_rd_data,
   output logic o_conv_busy
);
   typedef enum logic [1:0] {SABC_H_IDLE, SABC_H_SETUP, SABC_H_ACT,
      SABC_H_DONE} sabc_hstate_e;
   sabc_hstate_e state;
   logic is_read;
   logic [2:0] cnt;

   // Only convert and read codes start a pin sequence.
   wire op_go = (i_op == sabc_pkg::OP_CONV) ||
      (i_op == sabc_pkg::OP_READ);

   // Sequence: set read/convert and length, wait, raise enable.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= SABC_H_IDLE;
         is_read <= 1'b0;
         cnt <= 3'h0;
         o_busy <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= 12'h000;
         o_conv_busy <= 1'b0;
         bus.chip_en <= 1'b0;
         bus.sel_n <= 1'b1;
         bus.read_convert <= 1'b1;
         bus.byte_length_select <= 1'b0;
      end else begin
         o_rd_valid <= 1'b0;
         o_conv_busy <= bus.conv_busy;
         case (state)
            SABC_H_IDLE: begin
               if (op_go) begin
                  is_read <= (i_op == sabc_pkg::OP_READ);
                  bus.read_convert <= (i_op == sabc_pkg::OP_READ);
                  bus.byte_length_select <= i_len;
                  bus.sel_n <= 1'b0;
                  cnt <= 3'h0;
                  o_busy <= 1'b1;
                  state <= SABC_H_SETUP;
               end
            end
            SABC_H_SETUP: begin
               cnt <= cnt + 3'h1;
               if (cnt == 3'(sabc_pkg::SETTLE_CYC - 1)) begin
                  bus.chip_en <= 1'b1;
                  cnt <= 3'h0;
                  state <= SABC_H_ACT;
               end
            end
            SABC_H_ACT: begin
               cnt <= cnt + 3'h1;
               if (cnt == 3'h2) begin
                  bus.chip_en <= 1'b0;
                  o_rd_valid <= is_read;
                  o_rd_data <= bus.data_out & ~bus.data_oe_n;
                  state <= SABC_H_DONE;
               end
            end
            SABC_H_DONE: begin
               bus.sel_n <= 1'b1;
               bus.read_convert <= 1'b1;
               o_busy <= 1'b0;
               state <= SABC_H_IDLE;
            end
            default: state <= SABC_H_IDLE;
         endcase
      end
   end
endmodule

/* File: verif/sabc_asserts.sv */
// Watches the bus pins between the two ends.
module sabc_asserts (
   // Clock, reset and strap.
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_word_format_select,
   // Bus pins.
   input wire logic chip_en,
   input wire logic sel_n,
   input wire logic read_convert,
   input wire logic byte_length_select,
   input wire logic conv_busy,
   input wire logic [11:0] data_out,
   input wire logic [11:0] data_oe_n
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // Decoded requests; a read only counts while no conversion runs.
   wire st = chip_en & ~sel_n & ~read_convert;
   wire rd = chip_en & ~sel_n & read_convert;
   wire rd_ok = rd & ~conv_busy;
   wire wf = i_word_format_select;
   logic [9:0] cnt;
   logic len_q;
   // Busy length is counted, and the length latched only at a taken start,
   // so a refused start that restarted the sequencer would show up here.
   always_ff @(posedge i_mclk) begin
      cnt <= (i_rst | ~conv_busy) ? 10'h000 : cnt + 10'h001;
      if (st & ~conv_busy) begin
         len_q <= byte_length_select;
      end
   end
   property p_start; st & ~conv_busy |=> conv_busy; endproperty
   property p_len; $fell(conv_busy) |-> (len_q ?
      cnt inside {[10'h0F7:10'h0F9]} : cnt inside {[10'h173:10'h175]});
   endproperty
   property p_ign; st & conv_busy & (cnt < 10'h0F0) |=> conv_busy;
   endproperty
   property p_dark; conv_busy |-> data_oe_n == 12'hFFF; endproperty
   property p_idle; !rd |=> data_oe_n == 12'hFFF; endproperty
   property p_word; rd_ok & wf |=> data_oe_n == 12'h000; endproperty
   property p_msb; rd_ok & ~wf & ~byte_length_select |=>
      data_oe_n == 12'hF00; endproperty
   property p_lsb; rd_ok & ~wf & byte_length_select |=>
      data_oe_n == 12'hF00 && data_out[3:0] == 4'h0; endproperty
   property p_rc; $rose(chip_en) |-> $stable(read_convert) && !sel_n;
   endproperty
   property p_settle; chip_en |->
      byte_length_select == $past(byte_length_select, 4); endproperty
   a_start: assert property (p_start)
      else $error("start not taken");
   a_len: assert property (p_len)
      else $error("busy length wrong");
   a_ign: assert property (p_ign)
      else $error("start during busy");
   a_dark: assert property (p_dark)
      else $error("drivers on while busy");
   a_idle: assert property (p_idle)
      else $error("drivers on without read");
   a_word: assert property (p_word)
      else $error("word read enables");
   a_msb: assert property (p_msb)
      else $error("high byte enables");
   a_lsb: assert property (p_lsb)
      else $error("low byte format");
   a_rc: assert property (p_rc)
      else $error("convert level moved at enable");
   a_settle: assert property (p_settle)
      else $error("length select not settled");
   c_short: cover property (st & ~conv_busy & byte_length_select);
   c_refused: cover property (st & conv_busy);
   c_read: cover property (rd_ok);
endmodule

/* File: verif/sar_adc_bus_control_tb_top.sv */
// Drives the host user side and judges both ends.
module sar_adc_bus_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic wf = 1'b0, cmp = 1'b1, i_len = 1'b0;
   logic [1:0] i_op = 2'h0;
   logic o_busy, o_rd_valid, o_conv_busy, s_done, f_done;
   logic [11:0] o_rd_data, o_result, rd_q;
   int mismatches = 0, tests_run = 0, cyc = 0;
   sabc_if bus_if();
   // Clock at 25 MHz.
   always #20 i_mclk = ~i_mclk;
   sabc_dev sabc_dev_inst (.i_mclk, .i_rst, .bus(bus_if.dev),
      .i_word_format_select(wf), .i_cmp_high(cmp), .o_result,
      .o_short_cycle_done(s_done), .o_full_cycle_done(f_done));
   sabc_host sabc_host_inst (.i_mclk, .i_rst, .bus(bus_if.host), .i_op,
      .i_len, .o_busy, .o_rd_valid, .o_rd_data, .o_conv_busy);
   sabc_asserts sabc_asserts_inst (.i_mclk, .i_rst,
      .i_word_format_select(wf), .chip_en(bus_if.chip_en),
      .sel_n(bus_if.sel_n), .read_convert(bus_if.read_convert),
      .byte_length_select(bus_if.byte_length_select),
      .conv_busy(bus_if.conv_busy), .data_out(bus_if.data_out),
      .data_oe_n(bus_if.data_oe_n));
   // Read data is caught on its one-cycle pulse; a hang ends the run.
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (o_rd_valid === 1'b1) begin
         rd_q <= o_rd_data;
      end else if (i_op != sabc_pkg::OP_NONE) begin
         rd_q <= 12'hBAD;
      end
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   // The strap is only taken after reset, so each format needs a reset.
   task automatic reset_to(input logic f);
      @(posedge i_mclk);
      i_rst <= 1'b1;
      wf <= f;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
   endtask
   // One host operation; the host stays busy for eight cycles.
   task automatic op(input logic [1:0] o, input logic l, input logic c);
      @(posedge i_mclk);
      i_op <= o;
      i_len <= l;
      cmp <= c;
      @(posedge i_mclk);
      i_op <= sabc_pkg::OP_NONE;
      repeat (4) @(posedge i_mclk);
      chk(12'(o_busy), 12'h001);
      repeat (5) @(posedge i_mclk);
      chk(12'(o_busy), 12'h000);
   endtask
   // A conversion that never ends counts as a mismatch.
   task automatic wait_done;
      int n;
      for (n = 0; n < 500 && o_conv_busy !== 1'b0; n++) @(posedge i_mclk);
      if (n >= 500) begin
         mismatches++;
      end
      @(posedge i_mclk);
   endtask
   task automatic t_short;
      op(sabc_pkg::OP_CONV, 1'b1, 1'b1);
      chk(12'({o_conv_busy, f_done, s_done}), 12'h4);
      op(sabc_pkg::OP_CONV, 1'b0, 1'b1);
      wait_done();
      chk(12'(s_done), 12'h1);
      chk(o_result, 12'hFF0);
   endtask
   // Comparator low for the six upper steps, then high, so that bit
   // order and nibble placement both show in the result.
   task automatic t_full;
      op(sabc_pkg::OP_CONV, 1'b0, 1'b0);
      repeat (190) @(posedge i_mclk);
      cmp <= 1'b1;
      wait_done();
      chk(12'({f_done, s_done}), 12'h3);
      chk(o_result, 12'h03F);
      op(sabc_pkg::OP_READ, 1'b0, 1'b1);
      chk(rd_q, 12'h003);
      op(sabc_pkg::OP_READ, 1'b1, 1'b1);
      chk(rd_q, 12'h0F0);
      op(sabc_pkg::OP_READ, 1'b0, 1'b1);
      chk(rd_q, 12'h003);
   endtask
   task automatic t_word;
      op(sabc_pkg::OP_CONV, 1'b1, 1'b1);
      wait_done();
      op(sabc_pkg::OP_CONV, 1'b0, 1'b1);
      op(sabc_pkg::OP_READ, 1'b0, 1'b1);
      chk(rd_q, 12'h000);
      wait_done();
      op(sabc_pkg::OP_READ, 1'b1, 1'b1);
      chk(rd_q, 12'hFFF);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      reset_to(1'b0);
      t_short();
      t_full();
      reset_to(1'b1);
      t_word();
      give_verdict();
   end
endmodule
